//--- verilog/lvds_range_config_loader.sv
`timescale 1ns/1ps
`include "range_loader_consts.svh"

// How it works
// - both serial clock edges count toward words
// - short window leaves register unchanged
// - 24 edges load word, bit 23 first
// - all-zero word never loads
// - every full non-zero word applies unless a window opens with it; trailing partial dropped
// - busy falling edge opens window, restarts count, once the power-up delay is over
// - load right after twelfth falling edge
// - reset sets register to all ones
// - zero range code disables channel at once
// - first window opens 10ms after reset
module lvds_range_config_loader #(
    parameter int FIRST_WINDOW_CYCLES = `FIRST_WINDOW_CYCLES
) (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        serial_clock_in_i,
    input  wire logic                        serial_config_in_i,
    input  wire logic                        busy_i,
    input  wire logic                        conv_start_i,
    output logic [`CFG_WORD_BITS-1:0]        range_cfg_o,
    output logic [`CHAN_COUNT-1:0]           chan_enable_o,
    output logic                             window_open_o
);

    // ***************************************************
    // input synchronisers
    // ***************************************************
    logic [1:0] sck_sync_q;
    logic [1:0] sdi_sync_q;
    logic [1:0] busy_sync_q;
    logic       sck_prev_q;
    logic       busy_prev_q;

    // two flops on serial clock, data and busy pins, then edge history
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_sync_q  <= 2'h0;
            sdi_sync_q  <= 2'h0;
            busy_sync_q <= 2'h0;
            sck_prev_q  <= 1'b0;
            busy_prev_q <= 1'b0;
        end else begin
            sck_sync_q  <= {sck_sync_q[0], serial_clock_in_i};
            sdi_sync_q  <= {sdi_sync_q[0], serial_config_in_i};
            busy_sync_q <= {busy_sync_q[0], busy_i};
            sck_prev_q  <= sck_sync_q[1];
            busy_prev_q <= busy_sync_q[1];
        end
    end

    // history resets low like the idle pins, so no false edge after reset
    logic sck_edge;
    logic busy_fall;
    assign sck_edge  = sck_sync_q[1] ^ sck_prev_q;  // rising or falling
    assign busy_fall = busy_prev_q && !busy_sync_q[1];

    // ***************************************************
    // window control
    // ***************************************************
    range_loader_pkg::win_state_t state_q;
    logic [31:0]                  pwr_cnt_q;
    logic                         open_pulse;

    assign open_pulse = (state_q == range_loader_pkg::ST_POWERUP)
                        ? (pwr_cnt_q == 32'(FIRST_WINDOW_CYCLES - 1))
                        : busy_fall;

    // power-up delay counter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_cnt_q <= 32'h0;
        end else if (state_q == range_loader_pkg::ST_POWERUP) begin
            pwr_cnt_q <= pwr_cnt_q + 32'h1;
        end
    end

    // window opens after delay or busy fall, closes on conversion start
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= range_loader_pkg::ST_POWERUP;
        end else begin
            case (state_q)
                range_loader_pkg::ST_POWERUP: begin
                    if (open_pulse) begin
                        state_q <= range_loader_pkg::ST_OPEN;
                    end
                end
                range_loader_pkg::ST_CLOSED: begin
                    if (open_pulse) begin
                        state_q <= range_loader_pkg::ST_OPEN;
                    end
                end
                range_loader_pkg::ST_OPEN: begin
                    if (busy_fall) begin
                        state_q <= range_loader_pkg::ST_OPEN;  // reopen
                    end else if (conv_start_i) begin
                        state_q <= range_loader_pkg::ST_CLOSED;
                    end
                end
                default: begin
                    state_q <= range_loader_pkg::ST_CLOSED;
                end
            endcase
        end
    end

    logic in_window;
    assign in_window     = (state_q == range_loader_pkg::ST_OPEN) && !conv_start_i;
    assign window_open_o = (state_q == range_loader_pkg::ST_OPEN);

    // ***************************************************
    // word assembly
    // ***************************************************
    range_loader_pkg::cfg_word_t rx_word;

    // a word finishing as a window reopens is dropped with the partial
    ddr_word_shifter #(
        .WORD_BITS (`CFG_WORD_BITS)
    ) u_shifter (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (open_pulse),                  // restart per window
        .edge_i  (sck_edge && in_window),       // outside activity ignored
        .data_i  (sdi_sync_q[1]),
        .word_o  (rx_word)
    );

    // ***************************************************
    // range configuration register
    // ***************************************************
    // load on full non-zero word; 24th edge is the 12th falling edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            range_cfg_o <= `CFG_RESET_VALUE;
        end else if (rx_word.valid && (rx_word.word != '0)) begin
            range_cfg_o <= rx_word.word;
        end
    end

    // channel enables follow the register immediately
    always_comb begin
        for (int i = 0; i < `CHAN_COUNT; i++) begin
            chan_enable_o[i] =
                (range_cfg_o[i*`CHAN_CODE_BITS +: `CHAN_CODE_BITS] != 3'h0);
        end
    end

    // ***************************************************
    // checks
    // ***************************************************
    AST_RESET_ALL_ONES: assert property (@(posedge clk_i)
        $rose(!rst_i) |-> range_cfg_o == `CFG_RESET_VALUE)
        else $error("range register not all ones after reset");

    AST_ZERO_KEEPS: assert property (@(posedge clk_i) disable iff (rst_i)
        (rx_word.valid && rx_word.word == '0) |=> $stable(range_cfg_o))
        else $error("zero word changed range register");

    AST_LOAD_WORD: assert property (@(posedge clk_i) disable iff (rst_i)
        (rx_word.valid && rx_word.word != '0) |=> range_cfg_o == $past(rx_word.word))
        else $error("full word not loaded");

    AST_ONLY_ON_WORD: assert property (@(posedge clk_i) disable iff (rst_i)
        !rx_word.valid |=> $stable(range_cfg_o))
        else $error("register changed without full word");

    AST_LOAD_AFTER_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_word.valid |-> $past(sck_edge && in_window))
        else $error("word completed without serial edge");

    AST_CLOSED_IGNORE: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q != range_loader_pkg::ST_OPEN) |=> !rx_word.valid)
        else $error("word accepted outside window");

    AST_BUSY_OPENS: assert property (@(posedge clk_i) disable iff (rst_i)
        (busy_fall && state_q != range_loader_pkg::ST_POWERUP) |=> window_open_o)
        else $error("busy fall did not open window");

    AST_CHAN_DISABLE: assert property (@(posedge clk_i) disable iff (rst_i)
        (range_cfg_o[2:0] == 3'h0) |-> !chan_enable_o[0])
        else $error("zero code channel still enabled");

    // reset and power-up
    AST_RESET_HOLD: assert property (@(posedge clk_i)
        rst_i |-> (range_cfg_o == `CFG_RESET_VALUE) && (chan_enable_o == '1))
        else $error("register or enables wrong during reset");

    AST_POWERUP_OPEN: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == range_loader_pkg::ST_POWERUP && pwr_cnt_q == 32'(FIRST_WINDOW_CYCLES - 1))
        |=> window_open_o)
        else $error("first window not opened after power-up delay");

    AST_POWERUP_SHUT: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == range_loader_pkg::ST_POWERUP && pwr_cnt_q != 32'(FIRST_WINDOW_CYCLES - 1))
        |=> !window_open_o)
        else $error("window opened before power-up delay");

    // window and words
    AST_OPEN_DROPS: assert property (@(posedge clk_i) disable iff (rst_i)
        open_pulse |=> !rx_word.valid)
        else $error("word completed as window opened");

    AST_WORD_SPACING: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_word.valid |=> (!rx_word.valid) [*8])
        else $error("words closer than a full word of edges");

    AST_CONV_CLOSES: assert property (@(posedge clk_i) disable iff (rst_i)
        (window_open_o && conv_start_i && !busy_fall) |=> !window_open_o)
        else $error("window stayed open at conversion start");

    // channel enables
    AST_CHAN_ENABLE: assert property (@(posedge clk_i) disable iff (rst_i)
        (range_cfg_o[2:0] != 3'h0) |-> chan_enable_o[0])
        else $error("non-zero code channel disabled");

    AST_CHAN_TOP_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        (range_cfg_o[23:21] == 3'h0) |-> !chan_enable_o[7])
        else $error("zero code top channel still enabled");

endmodule : lvds_range_config_loader

//--- verilog/range_loader_consts.svh
`ifndef RANGE_LOADER_CONSTS_SVH
`define RANGE_LOADER_CONSTS_SVH

// word size in serial clock edges (both edges count)
`define CFG_WORD_BITS      24
// register contents after power-up or reset: widest bipolar range everywhere
`define CFG_RESET_VALUE    24'hFFFFFF
// bits per channel range code
`define CHAN_CODE_BITS     3
// number of channels held in the register
`define CHAN_COUNT         8
// delay from reset release to first window, in microseconds
`define FIRST_WINDOW_US    10000
// core clock rate in MHz
`define CLK_MHZ            25
// cycles for the first-window delay (exact product, no rounding)
`define FIRST_WINDOW_CYCLES (`FIRST_WINDOW_US * `CLK_MHZ)

`endif

//--- verilog/range_loader_pkg.sv
package range_loader_pkg;

    // received word and its completion strobe
    typedef struct packed {
        logic        valid;
        logic [23:0] word;
    } cfg_word_t;

    // window tracking states
    typedef enum logic [1:0] {
        ST_POWERUP,
        ST_CLOSED,
        ST_OPEN
    } win_state_t;

endpackage : range_loader_pkg

//--- verilog/ddr_word_shifter.sv
`timescale 1ns/1ps
`include "range_loader_consts.svh"

// shifts one data bit per serial clock edge, flags each full word unless clear_i comes with it
module ddr_word_shifter #(
    parameter int WORD_BITS = `CFG_WORD_BITS
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       clear_i,
    input  wire logic                       edge_i,
    input  wire logic                       data_i,
    output range_loader_pkg::cfg_word_t     word_o
);

    logic [WORD_BITS-1:0] shift_q;
    logic [4:0]           count_q;
    logic                 full_d;

    assign full_d = edge_i && (count_q == 5'(WORD_BITS - 1));

    // edge counter and shift register, restarted when a window opens
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_q <= '0;
            count_q <= '0;
        end else if (clear_i) begin
            shift_q <= '0;  // partial word dropped
            count_q <= '0;
        end else if (edge_i) begin
            shift_q <= {shift_q[WORD_BITS-2:0], data_i};  // msb first
            count_q <= full_d ? 5'h00 : count_q + 5'h01;  // both edges
        end
    end

    // complete word strobe
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            word_o <= '0;
        end else begin
            word_o.valid <= full_d && !clear_i;
            word_o.word  <= {shift_q[WORD_BITS-2:0], data_i};
        end
    end

endmodule : ddr_word_shifter

//--- verif/link_ctrl_model.sv
`timescale 1ns/1ps

// ****************************************
// controller side of the ddr config link
// ****************************************
module link_ctrl_model #(
    parameter int HALF_NS = 160
) (
    output logic serial_clock_o,
    output logic serial_data_o
);
    // both lines idle low outside a word
    initial begin
        serial_clock_o = 1'b0;
        serial_data_o  = 1'b0;
    end

    // one bit per clock edge, msb first, data settled half-way before each edge
    task automatic send(input int edges, input logic [23:0] bits);
        for (int i = 0; i < edges; i++) begin
            serial_data_o = bits[23 - (i % 24)];
            #(HALF_NS / 2);
            serial_clock_o = ~serial_clock_o;
            #(HALF_NS / 2);
        end
        serial_data_o = 1'b0;
    endtask : send
endmodule : link_ctrl_model

//--- verif/lvds_range_config_loader_tb.sv
`timescale 1ns/1ps
`include "range_loader_consts.svh"

// ****************************************
// bench for the range config loader
// ****************************************
module lvds_range_config_loader_tb;
    localparam int FIRST_CYC = 20;
    logic                       clk_i;
    logic                       rst_i;
    logic                       busy_i;
    logic                       conv_start_i;
    logic                       sclk;
    logic                       sdata;
    logic [`CFG_WORD_BITS-1:0]  cfg;
    logic [`CHAN_COUNT-1:0]     chan_en;
    logic                       win_open;
    logic [23:0]                cur;
    int                         err_total;
    int                         checks_done;

    // clock and parts
    initial clk_i = 1'b0;
    always #20 clk_i = ~clk_i;
    link_ctrl_model ctrl (.serial_clock_o(sclk), .serial_data_o(sdata));
    lvds_range_config_loader #(.FIRST_WINDOW_CYCLES(FIRST_CYC)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .serial_clock_in_i(sclk),
        .serial_config_in_i(sdata), .busy_i(busy_i), .conv_start_i(conv_start_i),
        .range_cfg_o(cfg), .chan_enable_o(chan_en), .window_open_o(win_open));

    // compare and count
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    // channel enables expected from a word
    function automatic logic [23:0] en_of(input logic [23:0] w);
        en_of = 24'h000000;
        for (int i = 0; i < 8; i++) en_of[i] = |w[3*i +: 3];
    endfunction : en_of

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask : cycles

    // busy pulse, then window must be open
    task automatic open_win;
        busy_i = 1'b1;
        cycles(2);
        busy_i = 1'b0;
        cycles(6);
        check({23'h0, win_open}, 24'h000001);
    endtask : open_win

    // send a word and let it land
    task automatic load(input int edges, input logic [23:0] w);
        ctrl.send(edges, w);
        cycles(8);
    endtask : load

    task automatic t_load;
        load(24, 24'h123456);
        cur = 24'h123456;
        check(cfg, cur);
        check({16'h0, chan_en}, en_of(cur));
        $display("test load done");
    endtask : t_load

    task automatic t_partial;
        open_win();
        load(22, 24'hABCDEF);
        check(cfg, cur);
        open_win();
        load(24, 24'h8421C7);
        cur = 24'h8421C7;
        check(cfg, cur);
        $display("test partial done");
    endtask : t_partial

    task automatic t_zero_multi;
        open_win();
        load(24, 24'h000000);
        check(cfg, cur);
        load(24, 24'h654321);
        check(cfg, 24'h654321);
        load(24, 24'h00F0F0);
        cur = 24'h00F0F0;
        check(cfg, cur);
        check({16'h0, chan_en}, en_of(cur));
        load(10, 24'hFFFFFF);
        check(cfg, cur);
        $display("test zero and multi done");
    endtask : t_zero_multi

    task automatic t_closed;
        conv_start_i = 1'b1;
        cycles(3);
        check({23'h0, win_open}, 24'h000000);
        load(24, 24'hFEDCBA);
        conv_start_i = 1'b0;
        check(cfg, cur);
        open_win();
        load(24, 24'hFEDCBA);
        check(cfg, 24'hFEDCBA);
        $display("test closed window done");
    endtask : t_closed

    // verdict and stop
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // watchdog
    initial begin
        #400000;
        err_total++;
        end_sim();
    end

    // reset, first window, then scenarios
    initial begin
        err_total = 0;
        checks_done = 0;
        rst_i = 1'b1;
        busy_i = 1'b0;
        conv_start_i = 1'b0;
        cycles(16);
        check(cfg, 24'hFFFFFF);
        check({16'h0, chan_en}, 24'h0000FF);
        rst_i = 1'b0;
        cur = 24'hFFFFFF;
        cycles(FIRST_CYC - 4);
        check({23'h0, win_open}, 24'h000000);
        cycles(8);
        check({23'h0, win_open}, 24'h000001);
        $display("test reset done");
        t_load();
        t_partial();
        t_zero_multi();
        t_closed();
        end_sim();
    end
endmodule : lvds_range_config_loader_tb
